// File: rtl/icts_pkg.sv
// Package for the instruction cycle timing sequencer
package icts_pkg;

	localparam int CNT_W = 8;

	// Operation classes the sequencer can time
	typedef enum logic [4:0] {
		ICTS_OP_SHIFT_REG     = 5'h00,
		ICTS_OP_SHIFT_MEM     = 5'h01,
		ICTS_OP_BRANCH        = 5'h02,
		ICTS_OP_DEC_BRANCH    = 5'h03,
		ICTS_OP_MULTI_MOVE    = 5'h04,
		ICTS_OP_EXT_REG       = 5'h05,
		ICTS_OP_EXT_MEM       = 5'h06,
		ICTS_OP_PERIPH_TO_MEM = 5'h07,
		ICTS_OP_PERIPH_TO_REG = 5'h08,
		ICTS_OP_TEST_SET      = 5'h09,
		ICTS_OP_SET_COND      = 5'h0a,
		ICTS_OP_EXC_ADDR_BUS  = 5'h0b,
		ICTS_OP_EXC_DIV_ZERO  = 5'h0c,
		ICTS_OP_EXC_ILLEGAL   = 5'h0d,
		ICTS_OP_EXC_TRAP      = 5'h0e,
		ICTS_OP_EXC_INTERRUPT = 5'h0f
	} icts_op_e;

	typedef enum logic [1:0] {
		ICTS_SZ_BYTE = 2'h0,
		ICTS_SZ_WORD = 2'h1,
		ICTS_SZ_LONG = 2'h2
	} icts_size_e;

	// One request to time
	typedef struct packed {
		icts_op_e         op;
		icts_size_e       size;
		logic             mem;
		logic             cond;
		logic             taken;
		logic             word_disp;
		logic [5:0]       count;
		logic [CNT_W-1:0] ea_clocks;
		logic [3:0]       ea_reads;
		logic [3:0]       ea_writes;
	} icts_req_s;

	// Cost of one sequence
	typedef struct packed {
		logic [CNT_W-1:0] clocks;
		logic [5:0]       reads;
		logic [5:0]       writes;
	} icts_cost_s;

	localparam logic [CNT_W-1:0] BUS_CYCLE_CLKS = 8'h04;

	localparam logic [CNT_W-1:0] EXC_ADDR_CLKS = 8'h32;
	localparam logic [5:0]       EXC_ADDR_RD   = 6'h04;
	localparam logic [5:0]       EXC_ADDR_WR   = 6'h07;
	localparam logic [CNT_W-1:0] EXC_DIV_CLKS  = 8'h2a;
	localparam logic [5:0]       EXC_DIV_RD    = 6'h05;
	localparam logic [5:0]       EXC_DIV_WR    = 6'h04;
	localparam logic [CNT_W-1:0] EXC_ILL_CLKS  = 8'h22;
	localparam logic [5:0]       EXC_ILL_RD    = 6'h04;
	localparam logic [5:0]       EXC_ILL_WR    = 6'h03;
	localparam logic [CNT_W-1:0] EXC_TRAP_CLKS = 8'h26;
	localparam logic [5:0]       EXC_TRAP_RD   = 6'h04;
	localparam logic [5:0]       EXC_TRAP_WR   = 6'h04;
	localparam logic [CNT_W-1:0] EXC_INT_CLKS  = 8'h2c;
	localparam logic [5:0]       EXC_INT_RD    = 6'h05;
	localparam logic [5:0]       EXC_INT_WR    = 6'h03;
	localparam logic [CNT_W-1:0] START_CLKS    = 8'h28;
	localparam logic [5:0]       START_RD      = 6'h06;

	localparam logic [CNT_W-1:0] SHIFT_BW_CLKS  = 8'h06;
	localparam logic [CNT_W-1:0] SHIFT_L_CLKS   = 8'h08;
	localparam logic [CNT_W-1:0] SHIFT_MEM_CLKS = 8'h08;
	localparam logic [CNT_W-1:0] BR_TAKEN_CLKS  = 8'h0a;
	localparam logic [CNT_W-1:0] BR_NT_B_CLKS   = 8'h08;
	localparam logic [CNT_W-1:0] BR_NT_W_CLKS   = 8'h0c;
	localparam logic [CNT_W-1:0] DB_TRUE_CLKS   = 8'h0c;
	localparam logic [CNT_W-1:0] DB_TAKEN_CLKS  = 8'h0a;
	localparam logic [CNT_W-1:0] DB_NT_CLKS     = 8'h0e;
	localparam logic [CNT_W-1:0] MM_BASE_CLKS   = 8'h0c;
	localparam logic [5:0]       MM_BASE_RD     = 6'h03;
	localparam logic [CNT_W-1:0] EXT_REG_BW     = 8'h04;
	localparam logic [CNT_W-1:0] EXT_REG_L      = 8'h08;
	localparam logic [CNT_W-1:0] EXT_MEM_BW     = 8'h12;
	localparam logic [CNT_W-1:0] EXT_MEM_L      = 8'h1e;
	localparam logic [CNT_W-1:0] PER_W_CLKS     = 8'h10;
	localparam logic [CNT_W-1:0] PER_L_CLKS     = 8'h18;
	localparam logic [CNT_W-1:0] TAS_REG_CLKS   = 8'h04;
	localparam logic [CNT_W-1:0] TAS_MEM_CLKS   = 8'h0a;
	localparam logic [CNT_W-1:0] SCC_F_CLKS     = 8'h04;
	localparam logic [CNT_W-1:0] SCC_T_CLKS     = 8'h06;
	localparam logic [CNT_W-1:0] SCC_MEM_CLKS   = 8'h08;

endpackage : icts_pkg

// File: rtl/icts_cost.sv
// Combinational cost table: clocks, reads and writes per request
module icts_cost (
	input  wire icts_pkg::icts_req_s  req_in,
	output icts_pkg::icts_cost_s      cost_out
);

	function automatic icts_pkg::icts_cost_s mk(input logic [7:0] c, input logic [5:0] r,
		input logic [5:0] w);
		icts_pkg::icts_cost_s t;
		t.clocks = c;
		t.reads  = r;
		t.writes = w;
		return t;
	endfunction : mk

	logic             is_long;
	logic [7:0]       n2;
	icts_pkg::icts_cost_s base;
	logic             add_ea;

	assign is_long = (req_in.size == icts_pkg::ICTS_SZ_LONG);
	assign n2      = {1'b0, req_in.count, 1'b0};

	always_comb begin
		base   = mk(icts_pkg::TAS_REG_CLKS, 6'h01, 6'h00);
		add_ea = 1'b0;
		case (req_in.op)
			icts_pkg::ICTS_OP_SHIFT_REG:
				base = mk((is_long ? icts_pkg::SHIFT_L_CLKS : icts_pkg::SHIFT_BW_CLKS) + n2,
					6'h01, 6'h00);
			icts_pkg::ICTS_OP_SHIFT_MEM: begin
				base   = mk(icts_pkg::SHIFT_MEM_CLKS, 6'h01, 6'h01);
				add_ea = 1'b1;
			end
			icts_pkg::ICTS_OP_BRANCH:
				if (req_in.taken)
					base = mk(icts_pkg::BR_TAKEN_CLKS, 6'h02, 6'h00);
				else if (req_in.word_disp)
					base = mk(icts_pkg::BR_NT_W_CLKS, 6'h02, 6'h00);
				else
					base = mk(icts_pkg::BR_NT_B_CLKS, 6'h01, 6'h00);
			icts_pkg::ICTS_OP_DEC_BRANCH:
				if (req_in.cond)
					base = mk(icts_pkg::DB_TRUE_CLKS, 6'h02, 6'h00);
				else if (req_in.taken)
					base = mk(icts_pkg::DB_TAKEN_CLKS, 6'h02, 6'h00);
				else
					base = mk(icts_pkg::DB_NT_CLKS, 6'h03, 6'h00);
			icts_pkg::ICTS_OP_MULTI_MOVE:
				if (is_long)
					base = mk(icts_pkg::MM_BASE_CLKS + {n2[5:0], 2'h0},
						icts_pkg::MM_BASE_RD + {req_in.count[4:0], 1'b0}, 6'h00);
				else
					base = mk(icts_pkg::MM_BASE_CLKS + {n2[6:0], 1'b0},
						icts_pkg::MM_BASE_RD + req_in.count, 6'h00);
			icts_pkg::ICTS_OP_EXT_REG:
				base = mk(is_long ? icts_pkg::EXT_REG_L : icts_pkg::EXT_REG_BW, 6'h01, 6'h00);
			icts_pkg::ICTS_OP_EXT_MEM:
				base = is_long ? mk(icts_pkg::EXT_MEM_L, 6'h05, 6'h02)
					: mk(icts_pkg::EXT_MEM_BW, 6'h03, 6'h01);
			icts_pkg::ICTS_OP_PERIPH_TO_MEM:
				base = is_long ? mk(icts_pkg::PER_L_CLKS, 6'h02, 6'h04)
					: mk(icts_pkg::PER_W_CLKS, 6'h02, 6'h02);
			icts_pkg::ICTS_OP_PERIPH_TO_REG:
				base = is_long ? mk(icts_pkg::PER_L_CLKS, 6'h06, 6'h00)
					: mk(icts_pkg::PER_W_CLKS, 6'h04, 6'h00);
			icts_pkg::ICTS_OP_TEST_SET:
				if (req_in.mem) begin
					base   = mk(icts_pkg::TAS_MEM_CLKS, 6'h01, 6'h01);
					add_ea = 1'b1;
				end else
					base = mk(icts_pkg::TAS_REG_CLKS, 6'h01, 6'h00);
			icts_pkg::ICTS_OP_SET_COND:
				if (req_in.mem) begin
					base   = mk(icts_pkg::SCC_MEM_CLKS, 6'h01, 6'h01);
					add_ea = 1'b1;
				end else
					base = mk(req_in.cond ? icts_pkg::SCC_T_CLKS : icts_pkg::SCC_F_CLKS,
						6'h01, 6'h00);
			icts_pkg::ICTS_OP_EXC_ADDR_BUS:
				base = mk(icts_pkg::EXC_ADDR_CLKS, icts_pkg::EXC_ADDR_RD, icts_pkg::EXC_ADDR_WR);
			icts_pkg::ICTS_OP_EXC_DIV_ZERO:
				base = mk(icts_pkg::EXC_DIV_CLKS, icts_pkg::EXC_DIV_RD, icts_pkg::EXC_DIV_WR);
			icts_pkg::ICTS_OP_EXC_ILLEGAL:
				base = mk(icts_pkg::EXC_ILL_CLKS, icts_pkg::EXC_ILL_RD, icts_pkg::EXC_ILL_WR);
			icts_pkg::ICTS_OP_EXC_TRAP:
				base = mk(icts_pkg::EXC_TRAP_CLKS, icts_pkg::EXC_TRAP_RD, icts_pkg::EXC_TRAP_WR);
			icts_pkg::ICTS_OP_EXC_INTERRUPT:
				base = mk(icts_pkg::EXC_INT_CLKS, icts_pkg::EXC_INT_RD, icts_pkg::EXC_INT_WR);
			default:
				base = mk(icts_pkg::TAS_REG_CLKS, 6'h01, 6'h00);
		endcase
		// index size carries no cost term
		cost_out = base;
		if (add_ea) begin
			cost_out.clocks = base.clocks + req_in.ea_clocks;
			cost_out.reads  = base.reads + {2'h0, req_in.ea_reads};
			cost_out.writes = base.writes + {2'h0, req_in.ea_writes};
		end
	end

endmodule : icts_cost

// File: rtl/icts_seq.sv
// Instruction and exception cycle timing sequencer
module icts_seq (
	input  wire                 sys_clk_in,
	input  wire                 sys_rst_in,
	input  wire                 halt_in,
	input  wire                 req_valid_in,
	input  wire icts_pkg::icts_req_s req_in,
	output logic                req_ready_out,
	output logic                bus_read_out,
	output logic                bus_write_out,
	output logic                done_out,
	output logic                exec_start_out,
	output logic [7:0]          clocks_out,
	output logic [5:0]          reads_out,
	output logic [5:0]          writes_out
);

	typedef enum logic [3:0] {
		ICTS_ST_RESET = 4'h1,
		ICTS_ST_START = 4'h2,
		ICTS_ST_IDLE  = 4'h4,
		ICTS_ST_RUN   = 4'h8
	} icts_state_e;

	icts_state_e          state_reg;
	icts_state_e          state_next;
	icts_pkg::icts_cost_s cost;
	icts_pkg::icts_cost_s job_reg;
	logic [7:0]           elapsed_reg;
	logic [5:0]           rd_done_reg;
	logic [5:0]           wr_done_reg;
	logic [5:0]           bus_total;
	logic [7:0]           bus_span;
	logic [1:0]           phase;
	logic                 in_window;
	logic                 rd_left;
	logic                 wr_left;
	logic                 last_clk;

	icts_cost u_cost (
		.req_in   (req_in),
		.cost_out (cost)
	);

	assign req_ready_out = (state_reg == ICTS_ST_IDLE);
	// whole budget lives in the job
	assign last_clk  = (elapsed_reg + 8'h01 == job_reg.clocks);
	// Longest job has 63 accesses, so six bits hold the sum
	assign bus_total = job_reg.reads + job_reg.writes;
	assign bus_span  = {2'h0, bus_total} * icts_pkg::BUS_CYCLE_CLKS;
	// accesses packed back to back at the tail
	// Tail packing keeps the last access inside the budget, no overrun into idle
	assign in_window = (state_reg == ICTS_ST_RUN || state_reg == ICTS_ST_START)
		&& (bus_total != 6'h00) && ((job_reg.clocks - elapsed_reg) <= bus_span);
	// Span is a whole number of accesses, so only the low bits matter
	assign phase     = elapsed_reg[1:0] - job_reg.clocks[1:0];
	assign rd_left   = (rd_done_reg != job_reg.reads);
	assign wr_left   = (wr_done_reg != job_reg.writes);

	always_comb begin
		case (state_reg)
			ICTS_ST_RESET: state_next = halt_in ? ICTS_ST_RESET : ICTS_ST_START;
			ICTS_ST_START: state_next = last_clk ? ICTS_ST_IDLE : ICTS_ST_START;
			ICTS_ST_IDLE:  state_next = req_valid_in ? ICTS_ST_RUN : ICTS_ST_IDLE;
			ICTS_ST_RUN:   state_next = last_clk ? ICTS_ST_IDLE : ICTS_ST_RUN;
			default:       state_next = ICTS_ST_RESET;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			state_reg <= ICTS_ST_RESET;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			job_reg <= '0;
		end else if (state_reg == ICTS_ST_RESET && !halt_in) begin
			job_reg <= {icts_pkg::START_CLKS, icts_pkg::START_RD, 6'h00};
		end else if (state_reg == ICTS_ST_IDLE && req_valid_in) begin
			job_reg <= cost;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || state_next == ICTS_ST_IDLE || state_reg == ICTS_ST_IDLE
			|| state_reg == ICTS_ST_RESET)
			elapsed_reg <= '0;
		else
			elapsed_reg <= elapsed_reg + 8'h01;
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || state_reg == ICTS_ST_IDLE || state_reg == ICTS_ST_RESET) begin
			rd_done_reg <= '0;
			wr_done_reg <= '0;
		end else if (in_window && phase == 2'h3) begin
			if (rd_left)
				rd_done_reg <= rd_done_reg + 6'h01;
			else if (wr_left)
				wr_done_reg <= wr_done_reg + 6'h01;
		end
	end

	// Reads go first, writes follow
	assign bus_read_out  = in_window && rd_left;
	assign bus_write_out = in_window && !rd_left && wr_left;
	assign done_out      = (state_reg == ICTS_ST_RUN) && last_clk;
	assign exec_start_out = (state_reg == ICTS_ST_START) && last_clk;

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			clocks_out <= '0;
			reads_out  <= '0;
			writes_out <= '0;
		end else if (state_reg == ICTS_ST_IDLE && req_valid_in) begin
			clocks_out <= cost.clocks;
			reads_out  <= cost.reads;
			writes_out <= cost.writes;
		end
	end

	property p_startup_len;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(state_reg == ICTS_ST_RESET && !halt_in) |-> ##40 exec_start_out;
	endproperty
	a_startup_len: assert property (p_startup_len) else $error("start-up not 40 clocks");

	property p_exc_addr;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_EXC_ADDR_BUS)
		|-> ##50 done_out;
	endproperty
	a_exc_addr: assert property (p_exc_addr) else $error("bus error entry not 50");

	property p_exc_int;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_EXC_INTERRUPT)
		|-> ##44 done_out;
	endproperty
	a_exc_int: assert property (p_exc_int) else $error("interrupt entry not 44");

	property p_exc_div;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_EXC_DIV_ZERO)
		|=> (clocks_out == 8'h2a && reads_out == 6'h05 && writes_out == 6'h04);
	endproperty
	a_exc_div: assert property (p_exc_div) else $error("divide entry cost wrong");

	property p_branch;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_BRANCH && req_in.taken)
		|=> clocks_out == 8'h0a ##9 done_out;
	endproperty
	a_branch: assert property (p_branch) else $error("taken branch not 10");

	property p_bus_len;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		$rose(bus_read_out) |-> bus_read_out[*4];
	endproperty
	a_bus_len: assert property (p_bus_len) else $error("bus read shorter than 4");

	property p_wr_len;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		$rose(bus_write_out) |-> bus_write_out[*4];
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("bus write shorter than 4");

	property p_exc_trap;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_EXC_TRAP)
		|=> (clocks_out == 8'h26 && reads_out == 6'h04 && writes_out == 6'h04) ##37 done_out;
	endproperty
	a_exc_trap: assert property (p_exc_trap) else $error("trap entry not 38");

	property p_multi_move;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_MULTI_MOVE
			&& req_in.size == icts_pkg::ICTS_SZ_WORD && req_in.count == 6'h02)
		|=> (clocks_out == 8'h14 && reads_out == 6'h05 && writes_out == 6'h00);
	endproperty
	a_multi_move: assert property (p_multi_move) else $error("word move of two wrong");

	property p_ext_mem;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_EXT_MEM
			&& req_in.size == icts_pkg::ICTS_SZ_LONG)
		|=> (clocks_out == 8'h1e && reads_out == 6'h05 && writes_out == 6'h02);
	endproperty
	a_ext_mem: assert property (p_ext_mem) else $error("long memory extended op wrong");

	property p_shift;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		(req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_SHIFT_REG
			&& req_in.size == icts_pkg::ICTS_SZ_WORD && req_in.count == 6'h01)
		|=> clocks_out == 8'h08;
	endproperty
	a_shift: assert property (p_shift) else $error("shift by one not 8");

	property p_done_idle;
		@(posedge sys_clk_in) disable iff (sys_rst_in)
		done_out |=> req_ready_out && !bus_read_out && !bus_write_out;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("bus active after done");

	c_startup: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) exec_start_out);
	c_write:   cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) $rose(bus_write_out));
	c_done:    cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) done_out);
	c_mm_long: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_MULTI_MOVE
		&& req_in.size == icts_pkg::ICTS_SZ_LONG);
	c_exc_int: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		req_ready_out && req_valid_in && req_in.op == icts_pkg::ICTS_OP_EXC_INTERRUPT);

endmodule : icts_seq

// File: test/icts_bus_model.sv
// Memory side observer: counts four-clock read and write accesses
module icts_bus_model (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        rd_in,
	input  wire        wr_in,
	output logic [7:0] reads_out,
	output logic [7:0] writes_out,
	output logic [7:0] bad_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] rd_run_reg;
	logic [1:0] wr_run_reg;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_run_reg <= 2'h0;
			wr_run_reg <= 2'h0;
			reads_out  <= 8'h00;
			writes_out <= 8'h00;
			bad_out    <= 8'h00;
		end else begin
			rd_run_reg <= rd_in ? rd_run_reg + 2'h1 : 2'h0;
			wr_run_reg <= wr_in ? wr_run_reg + 2'h1 : 2'h0;
			if (rd_in && rd_run_reg == 2'h3)
				reads_out <= reads_out + 8'h01;
			if (wr_in && wr_run_reg == 2'h3)
				writes_out <= writes_out + 8'h01;
			// Cut-short or overlapping strobes break the bus
			if ((!rd_in && rd_run_reg != 2'h0) || (!wr_in && wr_run_reg != 2'h0)
					|| (rd_in && wr_in))
				bad_out <= bad_out + 8'h01;
		end
	end
endmodule : icts_bus_model

// File: test/test_cpu_instruction_cycle_timing.sv
// Self-checking bench for the cycle timing sequencer
module test_cpu_instruction_cycle_timing;
	timeunit 1ns;
	timeprecision 1ns;

	logic                sys_clk_in = 1'b0;
	logic                sys_rst_in;
	logic                halt_in;
	logic                req_valid_in;
	icts_pkg::icts_req_s req_in;
	logic                req_ready_out;
	logic                bus_read_out;
	logic                bus_write_out;
	logic                done_out;
	logic                exec_start_out;
	logic [7:0]          clocks_out;
	logic [5:0]          reads_out;
	logic [5:0]          writes_out;
	logic [7:0]          bus_rd;
	logic [7:0]          bus_wr;
	logic [7:0]          bus_bad;
	logic [7:0]          c;
	int                  fail_count = 0;
	int                  n_checks = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	icts_seq uut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .halt_in(halt_in),
		.req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
		.bus_read_out(bus_read_out), .bus_write_out(bus_write_out), .done_out(done_out),
		.exec_start_out(exec_start_out), .clocks_out(clocks_out), .reads_out(reads_out),
		.writes_out(writes_out));

	icts_bus_model mem (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .rd_in(bus_read_out),
		.wr_in(bus_write_out), .reads_out(bus_rd), .writes_out(bus_wr), .bad_out(bus_bad));

	task automatic chk_cnt(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask : chk_cnt

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic results();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	function automatic icts_pkg::icts_cost_s exp_cost(icts_pkg::icts_req_s r);
		icts_pkg::icts_cost_s e;
		int cl, rd, wr, n;
		logic lg;
		n = r.count;
		lg = (r.size == icts_pkg::ICTS_SZ_LONG);
		rd = 1;
		wr = 0;
		case (r.op)
			icts_pkg::ICTS_OP_SHIFT_REG: cl = (lg ? 8 : 6) + 2 * n;
			icts_pkg::ICTS_OP_SHIFT_MEM: begin cl = 8; wr = 1; end
			icts_pkg::ICTS_OP_BRANCH: begin
				cl = r.taken ? 10 : (r.word_disp ? 12 : 8);
				rd = (r.taken || r.word_disp) ? 2 : 1;
			end
			icts_pkg::ICTS_OP_DEC_BRANCH: begin
				cl = r.cond ? 12 : (r.taken ? 10 : 14);
				rd = (cl == 14) ? 3 : 2;
			end
			icts_pkg::ICTS_OP_MULTI_MOVE: begin
				cl = 12 + (lg ? 8 : 4) * n;
				rd = 3 + (lg ? 2 : 1) * n;
			end
			icts_pkg::ICTS_OP_EXT_REG: cl = lg ? 8 : 4;
			icts_pkg::ICTS_OP_EXT_MEM: begin cl = lg ? 30 : 18; rd = lg ? 5 : 3; wr = lg ? 2 : 1; end
			icts_pkg::ICTS_OP_PERIPH_TO_MEM: begin cl = lg ? 24 : 16; rd = 2; wr = lg ? 4 : 2; end
			icts_pkg::ICTS_OP_PERIPH_TO_REG: begin cl = lg ? 24 : 16; rd = lg ? 6 : 4; end
			icts_pkg::ICTS_OP_TEST_SET: begin cl = r.mem ? 10 : 4; wr = r.mem; end
			icts_pkg::ICTS_OP_SET_COND: begin cl = r.mem ? 8 : (r.cond ? 6 : 4); wr = r.mem; end
			icts_pkg::ICTS_OP_EXC_ADDR_BUS: begin cl = 50; rd = 4; wr = 7; end
			icts_pkg::ICTS_OP_EXC_DIV_ZERO: begin cl = 42; rd = 5; wr = 4; end
			icts_pkg::ICTS_OP_EXC_ILLEGAL: begin cl = 34; rd = 4; wr = 3; end
			icts_pkg::ICTS_OP_EXC_TRAP: begin cl = 38; rd = 4; wr = 4; end
			default: begin cl = 44; rd = 5; wr = 3; end
		endcase
		if (r.op == icts_pkg::ICTS_OP_SHIFT_MEM || (r.mem && (r.op == icts_pkg::ICTS_OP_TEST_SET
				|| r.op == icts_pkg::ICTS_OP_SET_COND))) begin
			cl += r.ea_clocks;
			rd += r.ea_reads;
			wr += r.ea_writes;
		end
		e.clocks = 8'(cl);
		e.reads = 6'(rd);
		e.writes = 6'(wr);
		return e;
	endfunction : exp_cost

	// Valid stays up while busy, so each sequence also probes refusal
	task automatic run(input icts_pkg::icts_req_s r);
		icts_pkg::icts_cost_s e;
		logic [7:0] rd0, wr0, n, rdy;
		e = exp_cost(r);
		n = 8'h01;
		rdy = 8'h00;
		while (req_ready_out !== 1'b1 && n < 8'hff) begin @(negedge sys_clk_in); n++; end
		rd0 = bus_rd;
		wr0 = bus_wr;
		n = 8'h01;
		req_in = r;
		req_valid_in = 1'b1;
		@(negedge sys_clk_in);
		while (done_out !== 1'b1 && n < 8'hff) begin
			rdy += {7'h00, req_ready_out};
			@(negedge sys_clk_in);
			n++;
		end
		chk_cnt("cycles", e.clocks, n);
		chk_cnt("ready_while_busy", 8'h00, rdy);
		chk_cnt("clocks_out", e.clocks, clocks_out);
		chk_cnt("reads_out", {2'h0, e.reads}, {2'h0, reads_out});
		chk_cnt("writes_out", {2'h0, e.writes}, {2'h0, writes_out});
		@(negedge sys_clk_in);
		chk_cnt("bus_reads", {2'h0, e.reads}, bus_rd - rd0);
		chk_cnt("bus_writes", {2'h0, e.writes}, bus_wr - wr0);
		chk_bit("ready_after", 1'b1, req_ready_out);
	endtask : run

	task automatic go(input int o, input logic [31:0] v, input int n);
		icts_pkg::icts_req_s r;
		r = '0;
		r.op = icts_pkg::icts_op_e'(o[4:0]);
		r.size = icts_pkg::icts_size_e'(2'(v % 3));
		r.mem = v[3];
		r.cond = v[4];
		r.taken = v[5];
		r.word_disp = v[6];
		r.count = 6'(n);
		r.ea_reads = {2'h0, v[17:16]};
		r.ea_clocks = 8'(4 * v[17:16] + 2 * v[19:18]);
		run(r);
	endtask : go

	initial begin
		#1ms;
		fail_count++;
		$display("unexpected timeout: expected finish, seen hang");
		results();
	end

	initial begin
		logic [31:0] v;
		halt_in = 1'b1;
		sys_rst_in = 1'b1;
		req_valid_in = 1'b0;
		req_in = '0;
		void'($urandom(91626));
		repeat (12) @(negedge sys_clk_in);
		sys_rst_in = 1'b0;
		repeat (5) begin
			@(negedge sys_clk_in);
			chk_bit("start_while_halted", 1'b0, exec_start_out);
		end
		halt_in = 1'b0;
		c = 8'h00;
		while (exec_start_out !== 1'b1 && c < 8'hff) begin @(negedge sys_clk_in); c++; end
		chk_cnt("startup_clocks", 8'd40, c);
		@(negedge sys_clk_in);
		chk_cnt("startup_reads", 8'd6, bus_rd);
		chk_cnt("startup_writes", 8'd0, bus_wr);
		// Every code with eight counts spread from 0 up to 30
		for (int o = 0; o < 16; o++)
			for (int k = 0; k < 8; k++)
				go(o, 32'((k % 3) | (k << 3) | (k << 5) | (k << 16)), k * 30 / 7);
		for (int i = 0; i < 150; i++) begin
			v = $urandom;
			if (v[7]) begin
				req_valid_in = 1'b0;
				repeat (2) @(negedge sys_clk_in);
			end
			go($urandom % 16, v, $urandom % 31);
		end
		chk_cnt("bus_shape", 8'h00, bus_bad);
		results();
	end
endmodule : test_cpu_instruction_cycle_timing
